// *** design/bbse_pkg.sv ***
package bbse_pkg;

  // =========================================================================
  // Widths
  // =========================================================================
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned PC_W    = 21;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned BANK_W  = 4;
  localparam int unsigned SHORT_W = 8;
  localparam int unsigned LONG_W  = 11;
  localparam int unsigned BIT_W   = 3;

  // =========================================================================
  // Opcode fields
  // =========================================================================
  localparam int unsigned NZ_OPC_MSB  = 15;
  localparam int unsigned NZ_OPC_LSB  = 8;
  localparam int unsigned JMP_OPC_LSB = 11;
  localparam int unsigned SET_OPC_LSB = 12;
  localparam int unsigned BIT_MSB     = 11;
  localparam int unsigned BIT_LSB     = 9;
  localparam int unsigned ACC_BIT     = 8;
  localparam int unsigned FILE_MSB    = 7;

  localparam logic [7:0] OPC_NZ  = 8'hE1;
  localparam logic [4:0] OPC_JMP = 5'h1A;
  localparam logic [3:0] OPC_SET = 4'h8;

  // =========================================================================
  // Data space
  // =========================================================================
  localparam logic [7:0]        IDX_LIMIT   = 8'h5F;
  localparam logic [7:0]        ACC_SPLIT   = 8'h80;
  localparam logic [BANK_W-1:0] ACC_LO_PAGE = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HI_PAGE = 4'hF;
  localparam logic [DATA_W-1:0] BIT_ONE     = 8'h01;

  // =========================================================================
  // Reset values
  // =========================================================================
  localparam logic [INSTR_W-1:0] IR_RST   = 16'h0000;
  localparam logic [PC_W-1:0]    PC_RST   = 21'h000000;
  localparam logic [ADDR_W-1:0]  ADDR_RST = 12'h000;
  localparam logic [DATA_W-1:0]  DATA_RST = 8'h00;

  typedef enum logic [1:0] {
    BBSE_Q1 = 2'b00,
    BBSE_Q2 = 2'b01,
    BBSE_Q3 = 2'b11,
    BBSE_Q4 = 2'b10
  } bbse_phase_t;

  typedef enum logic [1:0] {
    BBSE_K_NONE = 2'b00,
    BBSE_K_NZ   = 2'b01,
    BBSE_K_JMP  = 2'b11,
    BBSE_K_SET  = 2'b10
  } bbse_kind_t;

endpackage

// *** design/bbse_target_adder.sv ***
module bbse_target_adder
  import bbse_pkg::*;
#(
  parameter int unsigned OFF_W = 8
) (
  // Operands
  input  wire logic [PC_W-1:0]  pc_i,
  input  wire logic [OFF_W-1:0] off_i,
  // Result
  output logic      [PC_W-1:0]  target_o
);

  logic [PC_W-1:0] step;

  // =========================================================================
  // Target arithmetic
  // =========================================================================
  // The offset counts words, so it is doubled after sign extension.
  always_comb begin
    step     = {{(PC_W - OFF_W - 1){off_i[OFF_W-1]}}, off_i, 1'b0};
    target_o = pc_i + step;
  end

endmodule

// *** design/bbse_core.sv ***
module bbse_core
  import bbse_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  // Instruction feed
  input  wire logic               instr_valid_i,
  input  wire logic [INSTR_W-1:0] instr_i,
  input  wire logic [PC_W-1:0]    pc_inc_i,
  output logic                    instr_ready_o,
  // Core state
  input  wire logic               zero_flag_i,
  input  wire logic [BANK_W-1:0]  bank_page_selector_i,
  input  wire logic               ext_set_en_i,
  input  wire logic [ADDR_W-1:0]  index_base_i,
  // Program counter
  output logic                    pc_load_o,
  output logic [PC_W-1:0]         pc_target_o,
  output logic                    flush_o,
  // Data space
  output logic                    reg_rd_o,
  output logic                    reg_we_o,
  output logic [ADDR_W-1:0]       reg_addr_o,
  output logic [DATA_W-1:0]       reg_wdata_o,
  input  wire logic [DATA_W-1:0]  reg_rdata_i,
  // Phase view
  output logic                    phase_q1_o
);

  // =========================================================================
  // State
  // =========================================================================
  bbse_phase_t          phase_q, phase_d;
  bbse_kind_t           kind_q, kind_d;
  logic [INSTR_W-1:0]   ir_q, ir_d;
  logic [PC_W-1:0]      pc_q, pc_d;
  logic [DATA_W-1:0]    rdata_q, rdata_d;
  logic                 taken_q, taken_d;
  logic                 flush_q, flush_d;
  logic                 ready_q, ready_d;
  logic                 pc_load_q, pc_load_d;
  logic [PC_W-1:0]      target_q, target_d;
  logic                 rd_q, rd_d;
  logic                 we_q, we_d;
  logic [ADDR_W-1:0]    addr_q, addr_d;
  logic [DATA_W-1:0]    wdata_q, wdata_d;
  logic                 q1_q, q1_d;

  logic [PC_W-1:0]      short_target;
  logic [PC_W-1:0]      long_target;
  logic [7:0]           file_f;
  logic [BIT_W-1:0]     bit_b;
  logic                 acc_a;
  logic [ADDR_W-1:0]    eff_addr;
  logic                 accept;

  // =========================================================================
  // Branch targets
  // =========================================================================
  bbse_target_adder #(
    .OFF_W (SHORT_W)
  ) u_short_target (
    .pc_i     (pc_q),
    .off_i    (ir_q[SHORT_W-1:0]),
    .target_o (short_target)
  );

  bbse_target_adder #(
    .OFF_W (LONG_W)
  ) u_long_target (
    .pc_i     (pc_q),
    .off_i    (ir_q[LONG_W-1:0]),
    .target_o (long_target)
  );

  // =========================================================================
  // Data address
  // =========================================================================
  // The file and access field decode reads the instruction word straight from the feed so
  // that the read strobe can go out in the phase after decode.
  always_comb begin
    file_f = instr_i[FILE_MSB:0];
    bit_b  = ir_q[BIT_MSB:BIT_LSB];
    acc_a  = instr_i[ACC_BIT];
    if (acc_a) begin
      eff_addr = {bank_page_selector_i, file_f};
    end else if (ext_set_en_i && (file_f <= IDX_LIMIT)) begin
      eff_addr = index_base_i + {{(ADDR_W - FILE_MSB - 1){1'b0}}, file_f};
    end else if (file_f < ACC_SPLIT) begin
      eff_addr = {ACC_LO_PAGE, file_f};
    end else begin
      eff_addr = {ACC_HI_PAGE, file_f};
    end
  end

  assign accept = (phase_q == BBSE_Q1) && ready_q && instr_valid_i;

  // =========================================================================
  // Next state
  // =========================================================================
  always_comb begin
    phase_d   = phase_q;
    kind_d    = kind_q;
    ir_d      = ir_q;
    pc_d      = pc_q;
    rdata_d   = rdata_q;
    taken_d   = taken_q;
    flush_d   = flush_q;
    pc_load_d = 1'b0;
    target_d  = target_q;
    rd_d      = 1'b0;
    we_d      = 1'b0;
    addr_d    = addr_q;
    wdata_d   = wdata_q;

    unique case (phase_q)
      BBSE_Q1: begin
        phase_d = BBSE_Q2;
        kind_d  = BBSE_K_NONE;
        taken_d = 1'b0;
        if (accept) begin
          ir_d = instr_i;
          pc_d = pc_inc_i;
          if (instr_i[NZ_OPC_MSB:NZ_OPC_LSB] == OPC_NZ) begin
            kind_d = BBSE_K_NZ;
          end else if (instr_i[NZ_OPC_MSB:JMP_OPC_LSB] == OPC_JMP) begin
            kind_d = BBSE_K_JMP;
          end else if (instr_i[NZ_OPC_MSB:SET_OPC_LSB] == OPC_SET) begin
            kind_d = BBSE_K_SET;
            rd_d   = 1'b1;
            addr_d = eff_addr;
          end
        end
      end
      BBSE_Q2: begin
        phase_d = BBSE_Q3;
        rdata_d = reg_rdata_i;
      end
      BBSE_Q3: begin
        phase_d = BBSE_Q4;
        if (kind_q == BBSE_K_NZ) begin
          taken_d   = !zero_flag_i;
          pc_load_d = !zero_flag_i;
          target_d  = short_target;
        end else if (kind_q == BBSE_K_JMP) begin
          taken_d   = 1'b1;
          pc_load_d = 1'b1;
          target_d  = long_target;
        end else if (kind_q == BBSE_K_SET) begin
          we_d    = 1'b1;
          wdata_d = rdata_q | (BIT_ONE << bit_b);
        end
      end
      BBSE_Q4: begin
        phase_d = BBSE_Q1;
        // A taken branch turns the next instruction cycle into a flush, so
        // the already fetched word is dropped rather than executed.
        flush_d = taken_q;
      end
    endcase

    ready_d = (phase_d == BBSE_Q1) && !flush_d;
    q1_d    = (phase_d == BBSE_Q1);
  end

  // =========================================================================
  // Registers
  // =========================================================================
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase_q   <= BBSE_Q1;
      kind_q    <= BBSE_K_NONE;
      ir_q      <= IR_RST;
      pc_q      <= PC_RST;
      rdata_q   <= DATA_RST;
      taken_q   <= 1'b0;
      flush_q   <= 1'b0;
      ready_q   <= 1'b1;
      pc_load_q <= 1'b0;
      target_q  <= PC_RST;
      rd_q      <= 1'b0;
      we_q      <= 1'b0;
      addr_q    <= ADDR_RST;
      wdata_q   <= DATA_RST;
      q1_q      <= 1'b1;
    end else begin
      phase_q   <= phase_d;
      kind_q    <= kind_d;
      ir_q      <= ir_d;
      pc_q      <= pc_d;
      rdata_q   <= rdata_d;
      taken_q   <= taken_d;
      flush_q   <= flush_d;
      ready_q   <= ready_d;
      pc_load_q <= pc_load_d;
      target_q  <= target_d;
      rd_q      <= rd_d;
      we_q      <= we_d;
      addr_q    <= addr_d;
      wdata_q   <= wdata_d;
      q1_q      <= q1_d;
    end
  end

  // =========================================================================
  // Outputs
  // =========================================================================
  assign instr_ready_o = ready_q;
  assign pc_load_o     = pc_load_q;
  assign pc_target_o   = target_q;
  assign flush_o       = flush_q;
  assign reg_rd_o      = rd_q;
  assign reg_we_o      = we_q;
  assign reg_addr_o    = addr_q;
  assign reg_wdata_o   = wdata_q;
  assign phase_q1_o    = q1_q;

endmodule

// *** tb/bbse_props.sv ***
module bbse_props
  import bbse_pkg::*;
(
  // Watched ports
  input wire logic               clk_i,
  input wire logic               reset_i,
  input wire logic               instr_valid_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic [PC_W-1:0]    pc_inc_i,
  input wire logic               instr_ready_o,
  input wire logic               zero_flag_i,
  input wire logic [BANK_W-1:0]  bank_page_selector_i,
  input wire logic               pc_load_o,
  input wire logic [PC_W-1:0]    pc_target_o,
  input wire logic               flush_o,
  input wire logic               reg_rd_o,
  input wire logic               reg_we_o,
  input wire logic [ADDR_W-1:0]  reg_addr_o,
  input wire logic [DATA_W-1:0]  reg_wdata_o,
  input wire logic [DATA_W-1:0]  reg_rdata_i,
  input wire logic               phase_q1_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Accepted instruction sequences
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic acc_w;
  assign acc_w = instr_valid_i && instr_ready_o && phase_q1_o;
  sequence s_nz;
    acc_w && instr_i[15:8] == OPC_NZ;
  endsequence
  sequence s_jmp;
    acc_w && instr_i[15:11] == OPC_JMP;
  endsequence
  sequence s_set;
    acc_w && instr_i[15:12] == OPC_SET;
  endsequence
  property p_nz_tgt;
    logic [PC_W-1:0] t;
    (s_nz, t = pc_inc_i + {{12{instr_i[7]}}, instr_i[7:0], 1'b0}) ##2 !zero_flag_i
      |-> ##1 pc_target_o == t;
  endproperty
  property p_jmp_tgt;
    logic [PC_W-1:0] t;
    (s_jmp, t = pc_inc_i + {{9{instr_i[10]}}, instr_i[10:0], 1'b0}) |-> ##3 pc_target_o == t;
  endproperty
  property p_set_data;
    logic [2:0] b;
    (s_set, b = instr_i[11:9]) |-> ##3 reg_wdata_o == ($past(reg_rdata_i, 2) | (BIT_ONE << b));
  endproperty
  property p_set_paged;
    logic [ADDR_W-1:0] t;
    (s_set ##0 instr_i[8], t = {bank_page_selector_i, instr_i[7:0]}) |-> ##1 reg_addr_o == t;
  endproperty
  chk_nz_taken: assert property (s_nz ##2 !zero_flag_i |-> ##1 pc_load_o ##1 flush_o)
    else $error("taken branch did not load and flush");
  chk_nz_idle: assert property (s_nz ##2 zero_flag_i |-> ##1 !pc_load_o ##1 instr_ready_o)
    else $error("untaken branch loaded or stalled");
  chk_nz_target: assert property (p_nz_tgt)
    else $error("short branch target wrong");
  chk_jmp_flush: assert property (s_jmp |-> ##3 pc_load_o ##1 flush_o [*4] ##1 !flush_o)
    else $error("jump load or flush length wrong");
  chk_jmp_target: assert property (p_jmp_tgt)
    else $error("long branch target wrong");
  chk_set_steps: assert property (s_set |-> ##1 reg_rd_o ##1 !reg_rd_o ##1 reg_we_o)
    else $error("bit set read or write strobe misplaced");
  chk_set_data: assert property (p_set_data)
    else $error("bit set write data wrong");
  chk_set_paged: assert property (p_set_paged)
    else $error("paged bit set address wrong");
  chk_load_q4: assert property (pc_load_o |=> phase_q1_o && !pc_load_o)
    else $error("program counter load outside last phase");
endmodule

// *** tb/testbench.sv ***
module testbench
  import bbse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, reset_i = 1'b1, instr_valid_i = 1'b0;
  logic zero_flag_i = 1'b0, ext_set_en_i = 1'b0;
  logic [INSTR_W-1:0] instr_i = 16'h0000;
  logic [PC_W-1:0] pc_inc_i = 21'h001000;
  logic [BANK_W-1:0] bank_page_selector_i = 4'h5;
  logic [ADDR_W-1:0] index_base_i = 12'h300;
  logic [DATA_W-1:0] reg_rdata_i = 8'h40;
  logic instr_ready_o, pc_load_o, flush_o, reg_rd_o, reg_we_o, phase_q1_o;
  logic [PC_W-1:0] pc_target_o;
  logic [ADDR_W-1:0] reg_addr_o;
  logic [DATA_W-1:0] reg_wdata_o;
  int failures = 0;
  int total_checks = 0;
  bbse_core DUT (
    .clk_i                (clk_i),
    .reset_i              (reset_i),
    .instr_valid_i        (instr_valid_i),
    .instr_i              (instr_i),
    .pc_inc_i             (pc_inc_i),
    .instr_ready_o        (instr_ready_o),
    .zero_flag_i          (zero_flag_i),
    .bank_page_selector_i (bank_page_selector_i),
    .ext_set_en_i         (ext_set_en_i),
    .index_base_i         (index_base_i),
    .pc_load_o            (pc_load_o),
    .pc_target_o          (pc_target_o),
    .flush_o              (flush_o),
    .reg_rd_o             (reg_rd_o),
    .reg_we_o             (reg_we_o),
    .reg_addr_o           (reg_addr_o),
    .reg_wdata_o          (reg_wdata_o),
    .reg_rdata_i          (reg_rdata_i),
    .phase_q1_o           (phase_q1_o)
  );
  always #20 clk_i = ~clk_i;
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic ck(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Waits for an accepting phase so that no word is dropped by a flush.
  task automatic go(input logic [15:0] w);
    int k;
    k = 0;
    while (!(phase_q1_o === 1'b1 && instr_ready_o === 1'b1) && k < 20) begin
      step(1);
      k++;
    end
    if (k == 20) begin
      failures++;
      $display("BAD %0t no accepting phase seen", $time);
    end
    instr_i = w;
    instr_valid_i = 1'b1;
    step(1);
    instr_valid_i = 1'b0;
  endtask
  task automatic t_br(input logic [15:0] w, input logic z, input bit tk, input logic [20:0] t);
    zero_flag_i = z;
    go(w);
    step(2);
    ck(pc_load_o, tk);
    if (tk) ck(pc_target_o, t);
    step(1);
    ck(flush_o, tk);
    ck(instr_ready_o, !tk);
    $display("branch test %h done", w);
  endtask
  task automatic t_set(input logic [15:0] w, input logic e, input logic [11:0] a, input logic [7:0] d);
    ext_set_en_i = e;
    go(w);
    ck(reg_rd_o, 1'b1);
    ck(reg_addr_o, a);
    step(2);
    ck(reg_we_o, 1'b1);
    ck(reg_wdata_o, d);
    ck(pc_load_o, 1'b0);
    $display("bit set test %h done", w);
  endtask
  // A reset in the middle of a flush must end the flush and restore the idle state.
  task automatic t_reset();
    zero_flag_i = 1'b0;
    go(16'hD000);
    step(3);
    ck(flush_o, 1'b1);
    reset_i = 1'b1;
    step(2);
    reset_i = 1'b0;
    ck(flush_o, 1'b0);
    ck(instr_ready_o, 1'b1);
    ck(phase_q1_o, 1'b1);
    ck(pc_load_o, 1'b0);
    ck(pc_target_o, 21'h000000);
    ck(reg_we_o, 1'b0);
    ck(reg_addr_o, 12'h000);
    ck(reg_wdata_o, 8'h00);
    $display("mid-run reset test done");
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    step(6);
    reset_i = 1'b0;
    ck(instr_ready_o, 1'b1);
    ck(phase_q1_o, 1'b1);
    t_br(16'hE180, 1'b0, 1, 21'h000F00);
    t_br(16'hE17F, 1'b0, 1, 21'h0010FE);
    t_br(16'hE17F, 1'b1, 0, 21'h000000);
    t_br(16'hD7FF, 1'b1, 1, 21'h000FFE);
    t_br(16'hD3FF, 1'b0, 1, 21'h0017FE);
    t_br(16'hD400, 1'b1, 1, 21'h000800);
    t_br(16'hE305, 1'b0, 0, 21'h000000);
    t_br(16'hD800, 1'b0, 0, 21'h000000);
    for (int b = 0; b < 8; b++) begin
      t_set({4'h8, b[2:0], 9'h110}, 1'b1, 12'h510, 8'h40 | (8'h01 << b));
    end
    t_set(16'h8034, 1'b0, 12'h034, 8'h41);
    t_set(16'h80C0, 1'b0, 12'hFC0, 8'h41);
    t_set(16'h825F, 1'b1, 12'h35F, 8'h42);
    t_set(16'h8460, 1'b1, 12'h060, 8'h44);
    t_reset();
    t_set(16'h8110, 1'b1, 12'h510, 8'h41);
    tally_and_finish();
  end
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule
bind bbse_core bbse_props u_props (
  .clk_i                (clk_i),
  .reset_i              (reset_i),
  .instr_valid_i        (instr_valid_i),
  .instr_i              (instr_i),
  .pc_inc_i             (pc_inc_i),
  .instr_ready_o        (instr_ready_o),
  .zero_flag_i          (zero_flag_i),
  .bank_page_selector_i (bank_page_selector_i),
  .pc_load_o            (pc_load_o),
  .pc_target_o          (pc_target_o),
  .flush_o              (flush_o),
  .reg_rd_o             (reg_rd_o),
  .reg_we_o             (reg_we_o),
  .reg_addr_o           (reg_addr_o),
  .reg_wdata_o          (reg_wdata_o),
  .reg_rdata_i          (reg_rdata_i),
  .phase_q1_o           (phase_q1_o)
);
